/* fcls_pkg.sv */
/*
 * fcls_pkg: register map, reset values and carrier types of the
 * fully-closed loop supervision block.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package fcls_pkg;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_THRESH = 8'h04;
  localparam logic [7:0]  ADDR_MULT   = 8'h08;
  localparam logic [7:0]  ADDR_MON    = 8'h0C;
  localparam logic [7:0]  ADDR_NUM    = 8'h10;
  localparam logic [7:0]  ADDR_DEN    = 8'h14;
  localparam logic [7:0]  ADDR_PITCH  = 8'h18;
  localparam logic [7:0]  ADDR_STAT   = 8'h1C;
  localparam logic [7:0]  ADDR_IRQST  = 8'h20;
  localparam logic [7:0]  ADDR_IRQCLR = 8'h24;
  localparam logic [7:0]  ADDR_IRQEN  = 8'h28;
  localparam logic [7:0]  ADDR_ERR    = 8'h2C;
  localparam logic [7:0]  ADDR_ARST   = 8'h30;
  // control word fields
  localparam int CTRL_FC_EN  = 0;
  localparam int CTRL_SPD_FB = 1;
  localparam int CTRL_G1_LSB = 2;
  localparam int CTRL_G2     = 4;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [30:0] THRESH_RST = 31'h0000_03E8;
  localparam logic [30:0] THRESH_MAX = 31'h4000_0000;
  localparam logic [6:0]  MULT_RST   = 7'h14;
  localparam logic [6:0]  MULT_MAX   = 7'h64;
  localparam logic [7:0]  MON1_RST   = 8'h02;
  localparam logic [7:0]  MON2_RST   = 8'h00;
  localparam logic [7:0]  MON_ERR    = 8'h07;
  localparam logic [31:0] NUM_RST    = 32'h0000_0001;
  localparam logic [31:0] DEN_RST    = 32'h0000_0001;
  localparam logic [31:0] PITCH_RST  = 32'h0000_0014;
  // interrupt bits
  localparam int IRQ_D10   = 0;
  localparam int IRQ_ALARM = 1;
  localparam int IRQ_CLEAR = 2;
  localparam int IRQ_W     = 3;
  // group-1 method code that applies the dynamic brake
  localparam logic [1:0]  G1_DBRAKE  = 2'h0;

  typedef struct packed {
    logic       active;      // an alarm holds the motor stopped
    logic       use_group1;  // group-1 method in force
    logic [1:0] g1_method;   // group-1 stop method code
    logic       zero_speed;  // speed reference forced to zero
  } fcls_stop_t;
endpackage : fcls_pkg

/* fcls_top.sv */
/*
 * fcls_top: fully-closed loop supervision: electronic gear on
 * position reference pulses, motor/load position error alarm with
 * per-rotation deviation carry, analog monitor routing, speed
 * feedback select and alarm stop by group, behind an APB slave.
 * Assumes encoder positions, pulses and alarm causes come from logic
 * on core_clk_i; the scale resolution is set up by software.
 */
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - gear ratio numerator over denominator scales pulses
// - compare load minus motor position against threshold
// - error above threshold raises overflow alarm
// - zero threshold disables the overflow alarm
// - per-rotation multiplier 0 to 100, default 20
// - multiplier zero uses external position unmodified
// - next rotation starts with deviation times 0.8 at default multiplier 20
// - monitor code 07 outputs position error
// - feedback source selects motor or external speed
// - feedback select ignored without fully-closed mode
// - group-1 alarm stops by group-1 method
// - group-2 alarm forces speed reference to zero
// - torque control always uses group-1 method
// - group-2 setting 1 uses group-1 method
// - only resettable alarms clear, once cause gone
module fcls_top #(
  parameter int          NALM      = 4,
  parameter logic [3:0]  ALM_GROUP2 = 4'h0,
  parameter logic [3:0]  ALM_RESET  = 4'hF,
  parameter logic        D10_RESET  = 1'b1
) (
  input  wire logic              core_clk_i,  // system clock
  input  wire logic              resetn_i,    // async reset
  input  wire logic              psel_i,      // apb select
  input  wire logic              penable_i,   // apb enable
  input  wire logic              pwrite_i,    // apb direction
  input  wire logic [7:0]        paddr_i,     // apb byte address
  input  wire logic [31:0]       pwdata_i,    // apb write data
  output logic      [31:0]       prdata_o,    // apb read data
  output logic                   pready_o,    // apb ready
  output logic                   pslverr_o,   // apb error
  input  wire logic              ref_pulse_i, // position ref pulse
  output logic                   step_o,      // scaled travel step
  input  wire logic signed [31:0] ext_pos_i,  // load position
  input  wire logic signed [31:0] mot_pos_i,  // motor position
  input  wire logic              rev_i,       // motor rotation mark
  input  wire logic [NALM-1:0]   alm_cause_i, // other alarm causes
  input  wire logic              torque_i,    // torque control mode
  input  wire logic              restart_i,   // drive restart pulse
  output logic                   ext_fb_o,    // external speed fb
  output logic signed [31:0]     mon1_o,      // monitor 1, 0.01 V lsb
  output logic signed [31:0]     mon2_o,      // monitor 2, 0.01 V lsb
  output fcls_pkg::fcls_stop_t   stop_o,      // stop action
  output logic                   d10_o,       // overflow alarm
  output logic                   irq_o        // interrupt level
);
  initial begin
    if (NALM < 1 || NALM > 4) $error("NALM must be 1 to 4");
  end

  logic [31:0]      ctrl;
  logic [30:0]      thresh;
  logic [6:0]       mult;
  logic [7:0]       mon1_sel, mon2_sel;
  logic [31:0]      num, den, pitch;
  logic [fcls_pkg::IRQ_W-1:0] irq_st, irq_en;
  logic [NALM-1:0]  alm;
  logic             d10;
  logic             fb_sel;
  logic signed [32:0] corr;
  logic [32:0]      acc;

  // apb decode; zero wait states
  logic wr_en, rd_en, hit;
  assign wr_en    = psel_i & penable_i & pwrite_i;
  assign rd_en    = psel_i & penable_i & ~pwrite_i;
  assign pready_o = 1'b1;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= fcls_pkg::ADDR_ARST) && (a[1:0] == 2'b00);
  endfunction : mapped

  assign hit       = mapped(paddr_i);
  assign pslverr_o = psel_i & penable_i & ~hit;

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = wr_en && (paddr_i == a);
  endfunction : wr_at

  // configuration registers
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl     <= fcls_pkg::CTRL_RST;
      thresh   <= fcls_pkg::THRESH_RST;
      mult     <= fcls_pkg::MULT_RST;
      mon1_sel <= fcls_pkg::MON1_RST;
      mon2_sel <= fcls_pkg::MON2_RST;
      num      <= fcls_pkg::NUM_RST;
      den      <= fcls_pkg::DEN_RST;
      pitch    <= fcls_pkg::PITCH_RST;
      irq_en   <= '0;
    end else begin
      if (wr_at(fcls_pkg::ADDR_CTRL)) ctrl <= pwdata_i;
      if (wr_at(fcls_pkg::ADDR_THRESH)) begin
        thresh <= (pwdata_i > 32'(fcls_pkg::THRESH_MAX)) ?
                  fcls_pkg::THRESH_MAX : pwdata_i[30:0];
      end
      if (wr_at(fcls_pkg::ADDR_MULT)) begin
        mult <= (pwdata_i > 32'(fcls_pkg::MULT_MAX)) ?
                fcls_pkg::MULT_MAX : pwdata_i[6:0];
      end
      if (wr_at(fcls_pkg::ADDR_MON)) begin
        mon1_sel <= pwdata_i[7:0];
        mon2_sel <= pwdata_i[15:8];
      end
      if (wr_at(fcls_pkg::ADDR_NUM)) num <= pwdata_i;
      if (wr_at(fcls_pkg::ADDR_DEN) && pwdata_i != 32'h0) begin
        den <= pwdata_i;
      end
      if (wr_at(fcls_pkg::ADDR_PITCH)) pitch <= pwdata_i;
      if (wr_at(fcls_pkg::ADDR_IRQEN)) begin
        irq_en <= pwdata_i[fcls_pkg::IRQ_W-1:0];
      end
    end
  end

  // electronic gear: each pulse adds num, steps drain den at a time
  logic [32:0] next_acc;
  always_comb begin
    next_acc = acc;
    if (acc >= {1'b0, den}) next_acc = acc - {1'b0, den};
    if (ref_pulse_i) next_acc = next_acc + {1'b0, num};
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc    <= '0;
      step_o <= 1'b0;
    end else begin
      acc    <= next_acc;
      step_o <= (acc >= {1'b0, den});
    end
  end

  // load/motor deviation with per-rotation carry
  logic signed [32:0] raw_dev, dev;
  logic signed [40:0] prod;
  logic        [32:0] dev_abs;
  assign raw_dev = 33'(ext_pos_i) - 33'(mot_pos_i);
  assign dev     = raw_dev - corr;
  assign prod    = 41'(raw_dev) * $signed({34'h0, mult});
  assign dev_abs = dev[32] ? 33'(-dev) : dev;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      corr <= '0;
    end else if (rev_i) begin
      // keeps (100 - mult)% of the deviation for the next rotation
      corr <= 33'(prod / 41'sd100);
    end
  end

  // motor/load error alarm
  logic over;
  logic arst;
  assign arst = wr_at(fcls_pkg::ADDR_ARST) & pwdata_i[0];
  assign over = (thresh != 31'h0) &&
                (dev_abs > {2'b00, thresh});

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      d10 <= 1'b0;
    end else if (over) begin
      d10 <= 1'b1;
    end else if (arst && D10_RESET) begin
      d10 <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NALM; gi++) begin : g_alm
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          alm[gi] <= 1'b0;
        end else if (alm_cause_i[gi]) begin
          alm[gi] <= 1'b1;
        end else if (arst && ALM_RESET[gi]) begin
          alm[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign d10_o = d10;

  // stop action by group
  logic g1_any, g2_any, any_alm;
  assign g1_any  = d10 | (|(alm & ~ALM_GROUP2[NALM-1:0]));
  assign g2_any  = |(alm & ALM_GROUP2[NALM-1:0]);
  assign any_alm = g1_any | g2_any;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stop_o <= '0;
    end else begin
      stop_o.active    <= any_alm;
      stop_o.g1_method <= ctrl[fcls_pkg::CTRL_G1_LSB +: 2];
      stop_o.use_group1 <= g1_any ||
        (g2_any && (torque_i || ctrl[fcls_pkg::CTRL_G2]));
      stop_o.zero_speed <= g2_any && !g1_any && !torque_i &&
        !ctrl[fcls_pkg::CTRL_G2];
    end
  end

  // speed feedback source, taken at reset release or restart
  logic fb_loaded;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fb_sel    <= 1'b0;
      fb_loaded <= 1'b0;
    end else if (!fb_loaded || restart_i) begin
      fb_sel    <= ctrl[fcls_pkg::CTRL_SPD_FB];
      fb_loaded <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_fb_o <= 1'b0;
    end else begin
      ext_fb_o <= fb_sel & ctrl[fcls_pkg::CTRL_FC_EN];
    end
  end

  // analog monitors: one lsb is one reference unit, 0.01 V
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mon1_o <= '0;
      mon2_o <= '0;
    end else begin
      mon1_o <= (mon1_sel == fcls_pkg::MON_ERR) ? dev[31:0] : '0;
      mon2_o <= (mon2_sel == fcls_pkg::MON_ERR) ? dev[31:0] : '0;
    end
  end

  // interrupts; a new event wins over a clear in the same cycle
  logic                       any_q;
  logic [fcls_pkg::IRQ_W-1:0] ev;
  assign ev = {any_q & ~any_alm, any_alm & ~any_q, over & ~d10};

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      any_q  <= 1'b0;
      irq_st <= '0;
    end else begin
      any_q <= any_alm;
      if (wr_at(fcls_pkg::ADDR_IRQCLR)) begin
        irq_st <= (irq_st & ~pwdata_i[fcls_pkg::IRQ_W-1:0]) | ev;
      end else begin
        irq_st <= irq_st | ev;
      end
    end
  end

  assign irq_o = |(irq_st & irq_en);

  // read mux
  always_comb begin
    prdata_o = '0;
    if (rd_en) begin
      case (paddr_i)
        fcls_pkg::ADDR_CTRL:   prdata_o = ctrl;
        fcls_pkg::ADDR_THRESH: prdata_o = {1'b0, thresh};
        fcls_pkg::ADDR_MULT:   prdata_o = {25'h0, mult};
        fcls_pkg::ADDR_MON:    prdata_o = {16'h0, mon2_sel, mon1_sel};
        fcls_pkg::ADDR_NUM:    prdata_o = num;
        fcls_pkg::ADDR_DEN:    prdata_o = den;
        fcls_pkg::ADDR_PITCH:  prdata_o = pitch;
        fcls_pkg::ADDR_STAT:   prdata_o = {21'h0, fb_sel, stop_o,
                                           ALM_PAD(alm), d10};
        fcls_pkg::ADDR_IRQST:  prdata_o = {29'h0, irq_st};
        fcls_pkg::ADDR_IRQEN:  prdata_o = {29'h0, irq_en};
        fcls_pkg::ADDR_ERR:    prdata_o = dev[31:0];
        default:               prdata_o = '0;
      endcase
    end
  end

  function automatic logic [3:0] ALM_PAD(input logic [NALM-1:0] a);
    ALM_PAD = 4'(a);
  endfunction : ALM_PAD

  // checks
  property p_d10_raise;
    @(posedge core_clk_i) disable iff (!resetn_i)
      over |=> d10_o;
  endproperty
  motor_load_error_overflow_alarm_raise: assert property (p_d10_raise)
    else $error("error overflow did not raise alarm");

  property p_zero_thresh;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (thresh == 31'h0 && !d10_o) |=> !d10_o;
  endproperty
  a_zero_thresh: assert property (p_zero_thresh)
    else $error("alarm raised with zero threshold");

  property p_over_cmp;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (thresh != 31'h0 && dev_abs > {2'b00, thresh}) |-> over;
  endproperty
  a_over_cmp: assert property (p_over_cmp)
    else $error("threshold compare missed");

  property p_latch;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (d10_o && !arst) |=> d10_o;
  endproperty
  a_latch: assert property (p_latch)
    else $error("alarm dropped without reset");

  property p_g1_stop;
    @(posedge core_clk_i) disable iff (!resetn_i)
      d10_o |=> (stop_o.active && stop_o.use_group1 && !stop_o.zero_speed);
  endproperty
  a_g1_stop: assert property (p_g1_stop)
    else $error("group-1 stop not applied");

  property p_torque;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (torque_i && (d10_o || |alm)) |=> stop_o.use_group1;
  endproperty
  a_torque: assert property (p_torque)
    else $error("torque mode not on group-1 stop");

  property p_mult_rng;
    @(posedge core_clk_i) disable iff (!resetn_i)
      mult <= fcls_pkg::MULT_MAX;
  endproperty
  a_mult_rng: assert property (p_mult_rng)
    else $error("multiplier above 100");

  property p_mult_zero;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (rev_i && mult == 7'h0) |=> (corr == 33'sh0);
  endproperty
  a_mult_zero: assert property (p_mult_zero)
    else $error("carry not cleared at zero multiplier");

  property p_fb_gate;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !ctrl[fcls_pkg::CTRL_FC_EN] |=> !ext_fb_o;
  endproperty
  a_fb_gate: assert property (p_fb_gate)
    else $error("external feedback without fully-closed mode");

  property p_mon;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (mon1_sel == fcls_pkg::MON_ERR) |=> (mon1_o == $past(dev[31:0]));
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor 1 not showing position error");

  property p_g2_zero;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (g2_any && !g1_any && !torque_i && !ctrl[fcls_pkg::CTRL_G2]) |=>
        (stop_o.active && stop_o.zero_speed && !stop_o.use_group1);
  endproperty
  a_g2_zero: assert property (p_g2_zero)
    else $error("group-2 stop did not zero speed");

  property p_g2_as_g1;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (g2_any && ctrl[fcls_pkg::CTRL_G2]) |=>
        (stop_o.use_group1 && !stop_o.zero_speed);
  endproperty
  a_g2_as_g1: assert property (p_g2_as_g1)
    else $error("group-2 setting 1 not on group-1 stop");

  property p_no_reset;
    @(posedge core_clk_i) disable iff (!resetn_i)
      ((alm & ~ALM_RESET[NALM-1:0]) != '0) |=>
        (($past(alm) & ~ALM_RESET[NALM-1:0] & ~alm) == '0);
  endproperty
  a_no_reset: assert property (p_no_reset)
    else $error("non-resettable alarm cleared");
endmodule : fcls_top

/* fcls_enc_model.sv */
/*
 * fcls_enc_model: motor encoder and external scale seen through a
 * serial converter; motor count moves every cycle, load follows it
 * with a commanded deviation.
 * Assumes one clock shared with the supervision block.
 */
`timescale 1ns/1ps
module fcls_enc_model #(
  parameter int PITCH = 20,        // scale pitch setting
  parameter int MULT  = 256        // converter multiplier
) (
  input  wire logic               clk_i,      // system clock
  input  wire logic               resetn_i,   // async reset
  input  wire logic signed [31:0] dev_i,      // load minus motor
  input  wire logic               rev_req_i,  // request rotation mark
  output logic signed [31:0]      ext_pos_o,  // load position
  output logic signed [31:0]      mot_pos_o,  // motor position
  output logic                    rev_o       // rotation mark pulse
);
  // counts per scale pitch after the converter
  localparam int RES = PITCH * MULT;
  logic signed [31:0] mot;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mot   <= 32'sh0000_0000;
      rev_o <= 1'b0;
    end else begin
      mot   <= (mot >= RES) ? 32'sh0000_0000 : mot + 32'sh0000_0001;
      rev_o <= rev_req_i;
    end
  end
  assign mot_pos_o = mot;
  assign ext_pos_o = mot + dev_i;
endmodule : fcls_enc_model

/* fully_closed_loop_supervision_tb.sv */
/*
 * fully_closed_loop_supervision_tb: register, gear, alarm, stop,
 * interrupt, monitor and feedback-select tests over APB.
 * Assumes fcls_top answers with zero wait states.
 */
`timescale 1ns/1ps
module fully_closed_loop_supervision_tb;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, step, rev, ext_fb, d10, irq, rev_req = 1'b0;
  logic ref_pulse = 1'b0, torque = 1'b0, restart = 1'b0;
  logic [3:0] alm = 4'h0;
  logic signed [31:0] ext_pos, mot_pos, mon1, mon2, dev = 32'sh0;
  fcls_pkg::fcls_stop_t stop;
  int n_mismatch = 0, checks_done = 0, nstep = 0, tick = 0;

  always #5 clk = ~clk;
  always @(posedge clk) begin
    tick <= tick + 1;
    if (step === 1'b1) nstep <= nstep + 1;
    if (tick == 20000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end

  fcls_enc_model fcls_enc_model_inst (.clk_i(clk), .resetn_i(rstn),
    .dev_i(dev), .rev_req_i(rev_req), .ext_pos_o(ext_pos),
    .mot_pos_o(mot_pos), .rev_o(rev));
  fcls_top #(.NALM(4), .ALM_GROUP2(4'h2), .ALM_RESET(4'h7),
    .D10_RESET(1'b1)) fcls_top_inst (.core_clk_i(clk), .resetn_i(rstn),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ref_pulse_i(ref_pulse), .step_o(step),
    .ext_pos_i(ext_pos), .mot_pos_i(mot_pos), .rev_i(rev),
    .alm_cause_i(alm), .torque_i(torque), .restart_i(restart),
    .ext_fb_o(ext_fb), .mon1_o(mon1), .mon2_o(mon2), .stop_o(stop),
    .d10_o(d10), .irq_o(irq));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one apb transfer; holds the request until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    chk({31'h0, pslverr}, {31'h0, a > 8'h30});
    psel <= 1'b0; pen <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask : rdchk

  // one-cycle pulse: 0 reference pulse, 1 rotation mark, else restart
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) ref_pulse <= 1'b1;
    else if (k == 1) rev_req <= 1'b1;
    else restart <= 1'b1;
    @(posedge clk);
    ref_pulse <= 1'b0;
    rev_req   <= 1'b0;
    restart   <= 1'b0;
  endtask : pulse

  initial begin
    cyc(6);
    rstn <= 1'b1;
    rdchk(fcls_pkg::ADDR_CTRL, 32'h0);
    rdchk(fcls_pkg::ADDR_THRESH, 32'h3E8);
    rdchk(fcls_pkg::ADDR_MULT, 32'h14);
    rdchk(fcls_pkg::ADDR_MON, 32'h0002);
    rdchk(fcls_pkg::ADDR_PITCH, 32'h14);
    rdchk(8'h34, 32'h0);
    // gear 512/200 on 25 pulses gives 64 steps
    wr(fcls_pkg::ADDR_NUM, 32'd512);
    wr(fcls_pkg::ADDR_DEN, 32'd200);
    wr(fcls_pkg::ADDR_DEN, 32'h0);
    rdchk(fcls_pkg::ADDR_DEN, 32'd200);
    nstep = 0;
    repeat (25) begin
      pulse(0);
      cyc(5);
    end
    cyc(10);
    chk(nstep, 32'd64);
    // position error alarm, unmodified external value
    wr(fcls_pkg::ADDR_MULT, 32'h0);
    wr(fcls_pkg::ADDR_MON, 32'h0007);
    wr(fcls_pkg::ADDR_IRQCLR, 32'h7);
    wr(fcls_pkg::ADDR_IRQEN, 32'h2);
    dev <= 32'sd1000;
    cyc(4);
    chk(mon1, 32'd1000);
    chk(mon2, 32'h0);
    pulse(1);
    cyc(3);
    chk(mon1, 32'd1000);
    chk({31'h0, d10}, 32'h0);
    dev <= 32'sd1001;
    cyc(4);
    chk({31'h0, d10}, 32'h1);
    chk({27'h0, stop}, 32'h18);
    chk({31'h0, irq}, 32'h1);
    wr(fcls_pkg::ADDR_ARST, 32'h1);
    cyc(3);
    chk({31'h0, d10}, 32'h1);
    dev <= 32'sd0;
    cyc(4);
    chk({31'h0, d10}, 32'h1);
    chk({27'h0, stop}, 32'h18);
    rdchk(fcls_pkg::ADDR_IRQST, 32'h3);
    wr(fcls_pkg::ADDR_IRQCLR, 32'h3);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(fcls_pkg::ADDR_ARST, 32'h1);
    cyc(3);
    chk({31'h0, d10}, 32'h0);
    chk({27'h0, stop}, 32'h0);
    rdchk(fcls_pkg::ADDR_IRQST, 32'h4);
    wr(fcls_pkg::ADDR_THRESH, 32'h0);
    dev <= 32'sd50000;
    cyc(4);
    chk({31'h0, d10}, 32'h0);
    // stop methods by group; masked then unmasked interrupt
    wr(fcls_pkg::ADDR_IRQEN, 32'h0);
    alm <= 4'h2;
    cyc(3);
    chk({27'h0, stop}, 32'h11);
    chk({31'h0, irq}, 32'h0);
    wr(fcls_pkg::ADDR_IRQEN, 32'h2);
    cyc(1);
    chk({31'h0, irq}, 32'h1);
    torque <= 1'b1;
    cyc(3);
    chk({27'h0, stop}, 32'h18);
    torque <= 1'b0;
    wr(fcls_pkg::ADDR_CTRL, 32'h10);
    cyc(3);
    chk({27'h0, stop}, 32'h18);
    alm <= 4'h0;
    wr(fcls_pkg::ADDR_CTRL, 32'h08);
    alm <= 4'h1;
    wr(fcls_pkg::ADDR_ARST, 32'h1);
    cyc(3);
    chk({27'h0, stop}, 32'h1C);
    alm <= 4'h8;
    cyc(2);
    alm <= 4'h0;
    wr(fcls_pkg::ADDR_ARST, 32'h1);
    cyc(3);
    chk({31'h0, stop.active}, 32'h1);
    rdchk(fcls_pkg::ADDR_STAT, 32'h390);
    // second reset, then rotation carry and feedback select
    @(posedge clk) rstn <= 1'b0;
    cyc(3);
    rstn <= 1'b1;
    wr(fcls_pkg::ADDR_THRESH, 32'h7FFF_FFFF);
    rdchk(fcls_pkg::ADDR_THRESH, 32'h4000_0000);
    wr(fcls_pkg::ADDR_MULT, 32'd200);
    rdchk(fcls_pkg::ADDR_MULT, 32'd100);
    wr(fcls_pkg::ADDR_MULT, 32'd20);
    wr(fcls_pkg::ADDR_MON, 32'h0700);
    dev <= 32'sd1000;
    pulse(1);
    cyc(4);
    chk(mon2, 32'd800);
    chk(mon1, 32'h0);
    rdchk(fcls_pkg::ADDR_ERR, 32'd800);
    wr(fcls_pkg::ADDR_CTRL, 32'h02);
    pulse(2);
    cyc(3);
    chk({31'h0, ext_fb}, 32'h0);
    // source 1 was taken at the restart; clearing it waits for another
    wr(fcls_pkg::ADDR_CTRL, 32'h01);
    cyc(3);
    chk({31'h0, ext_fb}, 32'h1);
    pulse(2);
    cyc(3);
    chk({31'h0, ext_fb}, 32'h0);
    wr(fcls_pkg::ADDR_CTRL, 32'h03);
    cyc(3);
    chk({31'h0, ext_fb}, 32'h0);
    pulse(2);
    cyc(3);
    chk({31'h0, ext_fb}, 32'h1);
    wrap_up();
  end
endmodule : fully_closed_loop_supervision_tb
